// ===== src/mds_pkg.sv
// Purpose: Shared constants and types for the multi-device FFT sequencer.
// Assumes: One system clock; all strobes are synchronous to it.
// Notes:   The mode word layout matches the secondary input bus bit order.
package mds_pkg;

   // ***************************************************************
   // Mode word layout
   // ***************************************************************
   typedef struct packed {
      logic       keepValid;    // Bit 15.
      logic [1:0] dumpSel;      // Bits 14:13.
      logic       simpleEnable; // Bit 12.
      logic       validDelay;   // Bit 11.
      logic [1:0] multiSel;     // Bits 10:9.
      logic [2:0] overlapSel;   // Bits 8:6.
      logic [1:0] windowSel;    // Bits 5:4.
      logic       shiftSel;     // Bit 3.
      logic [2:0] sizeSel;      // Bits 2:0.
   } mds_mode_t;

   localparam logic [15:0] MODE_RESET   = 16'h0000;
   localparam logic [1:0]  MULTI_SINGLE = 2'h0;
   localparam logic [1:0]  MULTI_CONC   = 2'h1;
   localparam logic [1:0]  MULTI_SEQ    = 2'h2;
   localparam logic [1:0]  MULTI_EXT    = 2'h3;

   localparam logic [2:0]  SIZE_16X16   = 3'h0;
   localparam logic [2:0]  SIZE_4X64    = 3'h1;
   localparam logic [2:0]  SIZE_256     = 3'h2;
   localparam logic [2:0]  SIZE_1024    = 3'h3;
   localparam logic [2:0]  SIZE_8X64R   = 3'h4;
   localparam logic [2:0]  SIZE_2X256R  = 3'h5;
   localparam logic [2:0]  SIZE_2X1024R = 3'h6;

   localparam logic [2:0]  OVL_NONE     = 3'h0;
   localparam logic [2:0]  OVL_50       = 3'h1;
   localparam logic [2:0]  OVL_50_DIV2  = 3'h2;
   localparam logic [2:0]  OVL_75       = 3'h3;
   localparam logic [2:0]  OVL_75_DIV4  = 3'h4;
   localparam logic [2:0]  OVL_DUAL_0   = 3'h5;
   localparam logic [2:0]  OVL_DUAL_50  = 3'h6;
   localparam logic [2:0]  OVL_DUAL_75  = 3'h7;

   // ***************************************************************
   // Timing counts in system clock cycles, priming in output strobes
   // ***************************************************************
   localparam int          CNT_W        = 12;
   localparam logic [2:0]  PRIME_STROBES = 3'h4;
   localparam logic [3:0]  SYNC_MAX     = 4'hc;
   localparam logic [11:0] XFORM_CYCLES = 12'h400;

   typedef enum logic [1:0] {
      LD_IDLE = 2'b01,
      LD_LOAD = 2'b10
   } mds_load_t;

   typedef enum logic [5:0] {
      CP_IDLE  = 6'b000001,
      CP_SYNC  = 6'b000010,
      CP_XFORM = 6'b000100,
      CP_PRIME = 6'b001000,
      CP_WAIT  = 6'b010000,
      CP_DUMP  = 6'b100000
   } mds_comp_t;

endpackage

// ===== src/mds_fft_sequencer.sv
// Purpose: Load, transform and dump sequencing for one FFT processor
//          working alone or among identical peers.
// Assumes: Strobes and neighbour flags are synchronous to clk_sys.
// Notes:   The arithmetic itself is modelled only by its duration.
//
// Summary of operation
// - Mode 01 loads concurrently with transforms; each dump follows its transform.
// - Real transforms in modes 01 and 10 take only the real bus.
// - Two overlap options divide the input strobe by two or four.
// - Mode 01 drops the load flag at 25, 50 or 100 percent loaded.
// - Multiple concurrent sets drop the flag in first and last sub-block.
// - Trigger edges are ignored while a load is already running.
// - Mode 10 loads, transforms and dumps as separate phases.
// - Every dump starts with four output strobes of priming.
// - Input synchronisation may add up to 12 clocks to a transform.
// - Mode 10 flag timing matches mode 01 without the double transition.
// - Mode 11 never overlaps I/O and loads extra samples for one, two or four transforms, as the overlap selects.
// - Mode 11 drops the flag after one normal block, then keeps loading.
// - The mode word is taken from the secondary bus while define is high.
// - A falling load-trigger edge starts the load procedure.
// - In multi modes valid waits for permit, while priming still proceeds.
`timescale 1ns/1ps

module mds_fft_sequencer
   import mds_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        modeDefine,
   input  wire logic [15:0] secondaryBus,
   input  wire logic        inputSampleStrobe,
   input  wire logic        outputSampleStrobe,
   input  wire logic        loadTrigger,
   input  wire logic        outputPermit,
   output mds_mode_t        modeWord,
   output logic             sampleTake,
   output logic             useImagBus,
   output logic             loadWindowFlag,
   output logic             loadBusy,
   output logic             xformBusy,
   output logic             resultsValid,
   output logic             outputDriveEn,
   output logic             resultWordStrobe
);

   // ***************************************************************
   // Size decoding
   // ***************************************************************
   function automatic logic [CNT_W-1:0] blockPoints(input logic [2:0] sz);
      case (sz)
         SIZE_1024, SIZE_2X1024R: blockPoints = 12'h400;
         SIZE_8X64R, SIZE_2X256R: blockPoints = 12'h200;
         default:                 blockPoints = 12'h100;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] subPoints(input logic [2:0] sz);
      case (sz)
         SIZE_4X64, SIZE_8X64R: subPoints = 12'h040;
         default:               subPoints = blockPoints(sz);
      endcase
   endfunction

   // ***************************************************************
   // Mode word capture
   // ***************************************************************
   mds_mode_t modeQ;
   mds_mode_t modeD;

   always_comb
   begin
      modeD = modeQ;
      if (modeDefine)
      begin
         modeD = mds_mode_t'(secondaryBus);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         modeQ <= mds_mode_t'(MODE_RESET);
      else
         modeQ <= modeD;
   end

   // ***************************************************************
   // Decoded configuration
   // ***************************************************************
   logic [CNT_W-1:0] blkN;
   logic [CNT_W-1:0] subN;
   logic [CNT_W-1:0] dropOff;
   logic [CNT_W-1:0] loadTotal;
   logic [CNT_W-1:0] dumpLen;
   logic [1:0]       divSel;
   logic [2:0]       xformsPerLoad;
   logic             isMulti;
   logic             isSeqMode;
   logic             multiSet;
   logic             dualSource;
   logic             realOnly;

   always_comb
   begin
      blkN       = blockPoints(modeQ.sizeSel);
      subN       = subPoints(modeQ.sizeSel);
      isMulti    = (modeQ.multiSel != MULTI_SINGLE);
      isSeqMode  = (modeQ.multiSel == MULTI_SEQ) || (modeQ.multiSel == MULTI_EXT);
      multiSet   = (subN != blkN);
      dualSource = (modeQ.overlapSel >= OVL_DUAL_0);
      realOnly   = (modeQ.multiSel == MULTI_CONC) || (modeQ.multiSel == MULTI_SEQ);
      divSel     = 2'h0;
      dropOff    = subN;
      xformsPerLoad = 3'h1;
      case (modeQ.overlapSel)
         OVL_50, OVL_DUAL_50:
         begin
            dropOff = subN >> 1;
            xformsPerLoad = 3'h2;
         end
         OVL_50_DIV2:
         begin
            dropOff = subN >> 1;
            xformsPerLoad = 3'h2;
            divSel = 2'h1;
         end
         OVL_75, OVL_DUAL_75:
         begin
            dropOff = subN >> 2;
            xformsPerLoad = 3'h4;
         end
         OVL_75_DIV4:
         begin
            dropOff = subN >> 2;
            xformsPerLoad = 3'h4;
            divSel = 2'h3;
         end
         default:
         begin
            dropOff = subN;
         end
      endcase
      loadTotal = blkN;
      if (modeQ.multiSel == MULTI_EXT)
      begin
         // One whole extra sub-block for sets, half a block otherwise.
         dropOff = blkN;
         loadTotal = blkN + (multiSet ? subN : (blkN >> 1));
      end
      else
      begin
         xformsPerLoad = 3'h1;
      end
      case (modeQ.dumpSel)
         2'h0:    dumpLen = blkN >> 2;
         2'h1:    dumpLen = blkN >> 1;
         2'h2:    dumpLen = blkN >> 1;
         default: dumpLen = blkN;
      endcase
   end

   // ***************************************************************
   // Load sequencer and load-window flag
   // ***************************************************************
   mds_load_t        ldStateQ;
   mds_load_t        ldStateD;
   logic [CNT_W-1:0] ldCntQ;
   logic [CNT_W-1:0] ldCntD;
   logic [1:0]       divCntQ;
   logic [1:0]       divCntD;
   logic             flagQ;
   logic             flagD;
   logic             trigPrevQ;
   logic             defPrevQ;
   logic             defRoseQ;
   logic             takeQ;
   logic             takeD;
   logic             imagQ;
   logic             imagD;
   logic             readyQ;
   logic             readyD;
   logic             readyClr;
   logic             compIdle;
   logic             startReq;
   logic             sampleEn;
   logic [CNT_W-1:0] lastSubStart;

   always_comb
   begin
      ldStateD = ldStateQ;
      ldCntD   = ldCntQ;
      divCntD  = divCntQ;
      flagD    = flagQ;
      takeD    = 1'b0;
      readyD   = readyQ;
      imagD    = imagQ;
      lastSubStart = blkN - subN;
      // The define edge is used one clock late, so the newly taken mode word decides.
      startReq = (trigPrevQ && !loadTrigger)
               || (modeQ.simpleEnable && isMulti && defRoseQ);
      sampleEn = inputSampleStrobe && ((divCntQ & divSel) == 2'h0);
      if (inputSampleStrobe)
         divCntD = divCntQ + 2'h1;
      if (readyClr)
         readyD = 1'b0;
      case (ldStateQ)
         LD_IDLE:
         begin
            // Sequential modes keep I/O apart from the transform.
            if (startReq && !readyQ && (!isSeqMode || compIdle))
            begin
               ldStateD = LD_LOAD;
               ldCntD   = '0;
               divCntD  = 2'h0;
               flagD    = 1'b1;
               // Modes 01 and 10 keep real data on the real bus, dual source or not.
               imagD    = (modeQ.sizeSel < SIZE_8X64R)
                        || (dualSource && !realOnly);
            end
         end
         LD_LOAD:
         begin
            // Further trigger edges are simply not looked at here.
            if (sampleEn)
            begin
               takeD  = 1'b1;
               ldCntD = ldCntQ + 12'h001;
               if (ldCntQ + 12'h001 == dropOff)
                  flagD = 1'b0;
               if (modeQ.multiSel == MULTI_CONC && multiSet && ldCntQ >= dropOff)
               begin
                  if (ldCntQ + 12'h001 == lastSubStart)
                     flagD = 1'b1;
                  if (ldCntQ + 12'h001 == lastSubStart + dropOff)
                     flagD = 1'b0;
               end
               if (ldCntQ + 12'h001 == loadTotal)
               begin
                  ldStateD = LD_IDLE;
                  flagD    = 1'b0;
                  readyD   = 1'b1; // Setting wins over the hand-off clear.
               end
            end
         end
         default:
         begin
            ldStateD = LD_IDLE;
            flagD    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ldStateQ  <= LD_IDLE;
         ldCntQ    <= '0;
         divCntQ   <= 2'h0;
         flagQ     <= 1'b0;
         trigPrevQ <= 1'b0;
         defPrevQ  <= 1'b0;
         defRoseQ  <= 1'b0;
         takeQ     <= 1'b0;
         imagQ     <= 1'b0;
         readyQ    <= 1'b0;
      end
      else
      begin
         ldStateQ  <= ldStateD;
         ldCntQ    <= ldCntD;
         divCntQ   <= divCntD;
         flagQ     <= flagD;
         trigPrevQ <= loadTrigger;
         defPrevQ  <= modeDefine;
         defRoseQ  <= modeDefine && !defPrevQ;
         takeQ     <= takeD;
         imagQ     <= imagD;
         readyQ    <= readyD;
      end
   end

   // ***************************************************************
   // Transform and dump sequencer
   // ***************************************************************
   mds_comp_t        cpStateQ;
   mds_comp_t        cpStateD;
   logic [CNT_W-1:0] cpCntQ;
   logic [CNT_W-1:0] cpCntD;
   logic [2:0]       xfLeftQ;
   logic [2:0]       xfLeftD;
   logic             validQ;
   logic             validD;
   logic             driveQ;
   logic             driveD;
   logic             wordQ;
   logic             wordD;

   always_comb
   begin
      cpStateD = cpStateQ;
      cpCntD   = cpCntQ;
      xfLeftD  = xfLeftQ;
      validD   = validQ;
      driveD   = driveQ;
      wordD    = 1'b0;
      readyClr = 1'b0;
      compIdle = (cpStateQ == CP_IDLE);
      case (cpStateQ)
         CP_IDLE:
         begin
            // A load in the concurrent mode may already run beside this.
            if (readyQ && ldStateQ == LD_IDLE || readyQ && !isSeqMode)
            begin
               readyClr = 1'b1;
               xfLeftD  = xformsPerLoad;
               cpCntD   = '0;
               cpStateD = CP_SYNC;
            end
         end
         CP_SYNC:
         begin
            // Align to the input strobe, never waiting past the limit.
            cpCntD = cpCntQ + 12'h001;
            if (inputSampleStrobe || cpCntQ[3:0] == SYNC_MAX - 4'h1)
            begin
               cpCntD   = '0;
               cpStateD = CP_XFORM;
            end
         end
         CP_XFORM:
         begin
            cpCntD = cpCntQ + 12'h001;
            if (cpCntQ == XFORM_CYCLES - 12'h001)
            begin
               cpCntD   = '0;
               cpStateD = CP_PRIME;
            end
         end
         CP_PRIME:
         begin
            // Priming runs even without permit so no gap opens later.
            if (outputSampleStrobe)
            begin
               cpCntD = cpCntQ + 12'h001;
               if (cpCntQ[2:0] == PRIME_STROBES - 3'h1)
               begin
                  cpCntD   = '0;
                  cpStateD = CP_WAIT;
               end
            end
         end
         CP_WAIT:
         begin
            if (outputPermit || !isMulti)
            begin
               validD   = 1'b1;
               driveD   = 1'b1;
               cpStateD = CP_DUMP;
            end
         end
         CP_DUMP:
         begin
            if (outputSampleStrobe)
            begin
               wordD  = 1'b1;
               cpCntD = cpCntQ + 12'h001;
               if (cpCntQ == dumpLen - 12'h001)
               begin
                  validD  = 1'b0;
                  driveD  = 1'b0;
                  cpCntD  = '0;
                  xfLeftD = xfLeftQ - 3'h1;
                  cpStateD = (xfLeftQ > 3'h1) ? CP_XFORM : CP_IDLE;
               end
            end
         end
         default:
         begin
            cpStateD = CP_IDLE;
            validD   = 1'b0;
            driveD   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cpStateQ <= CP_IDLE;
         cpCntQ   <= '0;
         xfLeftQ  <= 3'h0;
         validQ   <= 1'b0;
         driveQ   <= 1'b0;
         wordQ    <= 1'b0;
      end
      else
      begin
         cpStateQ <= cpStateD;
         cpCntQ   <= cpCntD;
         xfLeftQ  <= xfLeftD;
         validQ   <= validD;
         driveQ   <= driveD;
         wordQ    <= wordD;
      end
   end

   // ***************************************************************
   // Outputs, all straight from flip-flops
   // ***************************************************************
   logic busyLoadQ;
   logic busyXfQ;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         busyLoadQ <= 1'b0;
         busyXfQ   <= 1'b0;
      end
      else
      begin
         busyLoadQ <= (ldStateD == LD_LOAD);
         busyXfQ   <= (cpStateD == CP_SYNC) || (cpStateD == CP_XFORM);
      end
   end

   assign modeWord         = modeQ;
   assign sampleTake       = takeQ;
   assign useImagBus       = imagQ;
   assign loadWindowFlag   = flagQ;
   assign loadBusy         = busyLoadQ;
   assign xformBusy        = busyXfQ;
   assign resultsValid     = validQ;
   assign outputDriveEn    = driveQ;
   assign resultWordStrobe = wordQ;

endmodule

// ===== bench/mds_seq_asserts.sv
// Purpose: Port-level assertions for the FFT sequencer.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached by bind; checks tie outputs to their causes, to each other and to a run-length limit.
`timescale 1ns/1ps

module mds_seq_asserts
   import mds_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        modeDefine,
   input wire logic [15:0] secondaryBus,
   input wire logic        inputSampleStrobe,
   input wire logic        outputSampleStrobe,
   input wire logic        loadTrigger,
   input wire logic        outputPermit,
   input wire mds_mode_t   modeWord,
   input wire logic        sampleTake,
   input wire logic        useImagBus,
   input wire logic        loadWindowFlag,
   input wire logic        loadBusy,
   input wire logic        xformBusy,
   input wire logic        resultsValid,
   input wire logic        outputDriveEn,
   input wire logic        resultWordStrobe
);
   // ****************************************
   // Transform run length
   // ****************************************
   localparam int XF_MAX = 1038;
   logic [11:0] xfRun_q;
   logic [11:0] xfRun_d;

   always_comb
   begin
      xfRun_d = xformBusy ? xfRun_q + 12'h001 : 12'h000;
   end

   always_ff @(posedge clk_sys)
   begin
      xfRun_q <= rst ? 12'h000 : xfRun_d;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   chk_mode_take: assert property (modeDefine |=> modeWord == $past(secondaryBus))
      else $error("mode word not taken from bus");
   chk_mode_hold: assert property (!modeDefine |=> $stable(modeWord))
      else $error("mode word changed without define");
   chk_drive_valid: assert property (outputDriveEn == resultsValid)
      else $error("output enable differs from valid");
   chk_valid_permit: assert property ($rose(resultsValid) && modeWord.multiSel != MULTI_SINGLE
      |-> $past(outputPermit))
      else $error("valid rose without permit");
   chk_take_cause: assert property (sampleTake |-> $past(inputSampleStrobe))
      else $error("sample taken without strobe");
   chk_word_cause: assert property (resultWordStrobe
      |-> $past(outputSampleStrobe) && $past(resultsValid))
      else $error("result word without strobe and valid");
   chk_phase_split: assert property ((modeWord.multiSel == MULTI_SEQ
      || modeWord.multiSel == MULTI_EXT) |-> !(loadBusy && xformBusy))
      else $error("load overlaps transform");
   chk_single_drop: assert property (modeWord.multiSel == MULTI_SEQ && loadBusy
      && !loadWindowFlag |=> !loadWindowFlag)
      else $error("second flag transition in sequential mode");
   chk_xform_time: assert property (xfRun_q <= XF_MAX)
      else $error("transform ran too long");
   chk_flag_busy: assert property (loadWindowFlag |-> loadBusy)
      else $error("flag high outside a load");

   cov_valid: cover property ($rose(resultsValid));
   cov_word: cover property (resultWordStrobe);
   cov_double: cover property ($rose(loadWindowFlag) && $past(loadBusy));
endmodule

bind mds_fft_sequencer mds_seq_asserts chk_u (
   .clk_sys(clk_sys), .rst(rst), .modeDefine(modeDefine), .secondaryBus(secondaryBus),
   .inputSampleStrobe(inputSampleStrobe), .outputSampleStrobe(outputSampleStrobe),
   .loadTrigger(loadTrigger), .outputPermit(outputPermit), .modeWord(modeWord),
   .sampleTake(sampleTake), .useImagBus(useImagBus), .loadWindowFlag(loadWindowFlag),
   .loadBusy(loadBusy), .xformBusy(xformBusy), .resultsValid(resultsValid),
   .outputDriveEn(outputDriveEn), .resultWordStrobe(resultWordStrobe)
);

// ===== bench/mds_peer_model.sv
// Purpose: Upstream peer device: load-window flag and results valid.
// Assumes: Everything changes on clk_sys edges only.
// Notes:   The flag pulse is fired on request; its falling edge hands loading on.
`timescale 1ns/1ps

module mds_peer_model #(
   parameter int FLAG_LEN = 3
)(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic fireReq,
   input  wire logic holdValid,
   output logic      peerFlag,
   output logic      permitOut
);
   logic [3:0] flagCnt_q;
   logic [3:0] flagCnt_d;
   logic       valid_q;
   logic       valid_d;

   always_comb
   begin
      flagCnt_d = fireReq ? 4'(FLAG_LEN) : (flagCnt_q != 4'h0) ? flagCnt_q - 4'h1 : 4'h0;
      valid_d   = holdValid;
   end

   always_ff @(posedge clk_sys)
   begin
      flagCnt_q <= rst ? 4'h0 : flagCnt_d;
      valid_q   <= rst ? 1'b0 : valid_d;
   end

   assign peerFlag  = flagCnt_q != 4'h0;
   assign permitOut = ~valid_q;
endmodule

// ===== bench/mds_fft_sequencer_test.sv
// Purpose: Self-checking bench for the FFT sequencer.
// Assumes: Inputs change 1 ns after each rising edge.
// Notes:   Every load is compared with expectations worked out here.
`timescale 1ns/1ps

module mds_fft_sequencer_test import mds_pkg::*;;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        modeDefine = 1'b0;
   logic [15:0] secondaryBus = 16'h0000;
   logic        inputSampleStrobe = 1'b0;
   logic        outputSampleStrobe = 1'b0;
   logic        fireReq = 1'b0;
   logic        holdValid = 1'b0;
   logic        loadTrigger;
   logic        outputPermit;
   mds_mode_t   modeWord;
   mds_mode_t   curMode;
   logic        sampleTake, useImagBus, loadWindowFlag, loadBusy, xformBusy;
   logic        resultsValid, resultWordStrobe;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          seed = 72;
   int          cycles = 0;
   int          words, vseen;

   mds_fft_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .modeDefine(modeDefine),
      .secondaryBus(secondaryBus), .inputSampleStrobe(inputSampleStrobe),
      .outputSampleStrobe(outputSampleStrobe), .loadTrigger(loadTrigger),
      .outputPermit(outputPermit), .modeWord(modeWord), .sampleTake(sampleTake),
      .useImagBus(useImagBus), .loadWindowFlag(loadWindowFlag), .loadBusy(loadBusy),
      .xformBusy(xformBusy), .resultsValid(resultsValid), .outputDriveEn(),
      .resultWordStrobe(resultWordStrobe));
   mds_peer_model #(.FLAG_LEN(3)) peer_u (.clk_sys(clk_sys), .rst(rst), .fireReq(fireReq),
      .holdValid(holdValid), .peerFlag(loadTrigger), .permitOut(outputPermit));

   always #10 clk_sys = ~clk_sys;

   // ****************************************
   // Helpers
   // ****************************************
   task automatic stop_test();
      $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (exp !== got)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Outside define the bus toggles every clock, alternating the mode word and its inverse.
   task automatic tick();
      @(posedge clk_sys);
      #1;
      if (!modeDefine) secondaryBus = ~secondaryBus;
   endtask

   task automatic step(input logic st);
      outputSampleStrobe = st;
      tick();
      if (resultWordStrobe === 1'b1) words++;
      if (resultsValid === 1'b1) vseen = 1;
   endtask

   // Expected counts come from block size, set size, overlap and multi mode.
   task automatic run_load(input logic [1:0] m, input logic [2:0] s, input logic [2:0] o);
      int blk, sub, dv, drop, total, rises, drop1, dropN, takes, cyc, start, imag, e;
      bit sets, busySeen, flagPrev;
      curMode = mds_mode_t'($random(seed));
      // One scenario starts its load from the define edge instead of the trigger.
      curMode.simpleEnable = (o == OVL_50_DIV2);
      curMode.multiSel = m;
      curMode.sizeSel = s;
      curMode.overlapSel = o;
      rst = 1'b1;
      tick();
      rst = 1'b0;
      modeDefine = 1'b1;
      secondaryBus = curMode;
      tick();
      modeDefine = 1'b0;
      check("modeWord", curMode, modeWord);
      tick();
      check("modeHold", curMode, modeWord);
      blk = (s == SIZE_8X64R || s == SIZE_2X256R) ? 512 : 256;
      sets = (s == SIZE_4X64 || s == SIZE_8X64R);
      sub = sets ? 64 : blk;
      dv = (o == OVL_50_DIV2) ? 2 : (o == OVL_75_DIV4) ? 4 : 1;
      drop = (o inside {OVL_50, OVL_50_DIV2, OVL_DUAL_50}) ? sub / 2 :
             (o inside {OVL_75, OVL_75_DIV4, OVL_DUAL_75}) ? sub / 4 : sub;
      drop = (m == MULTI_EXT) ? blk : drop;
      total = (m == MULTI_EXT) ? blk + (sets ? 64 : blk / 2) : blk;
      cyc = 0;
      takes = 0;
      rises = 0;
      drop1 = -1;
      dropN = -1;
      busySeen = 0;
      flagPrev = 0;
      start = 0;
      imag = 0;
      while (cyc < 9000 && !(busySeen && loadBusy !== 1'b1))
      begin
         fireReq = (cyc == 2 || cyc == 60);
         inputSampleStrobe = ($unsigned(cyc) % 4 == 1);
         tick();
         cyc++;
         if (loadBusy === 1'b1 && !busySeen)
         begin
            start = cyc;
            imag = (useImagBus === 1'b1);
         end
         busySeen = busySeen | (loadBusy === 1'b1);
         if (sampleTake === 1'b1) takes++;
         if (loadWindowFlag === 1'b1 && !flagPrev) rises++;
         if (loadWindowFlag !== 1'b1 && flagPrev)
         begin
            if (drop1 < 0) drop1 = takes;
            dropN = takes;
         end
         flagPrev = (loadWindowFlag === 1'b1);
      end
      inputSampleStrobe = 1'b0;
      fireReq = 1'b0;
      e = (total - 1) * dv * 4;
      check("takes", total, takes);
      check("firstDrop", drop, drop1);
      check("flagRises", (m == MULTI_CONC && sets) ? 2 : 1, rises);
      check("lastDrop", (m == MULTI_CONC && sets) ? blk - 64 + drop : drop, dropN);
      check("imagBus", (s <= SIZE_1024 || (o >= OVL_DUAL_0 && m != MULTI_CONC
         && m != MULTI_SEQ)), imag);
      check("loadStart", curMode.simpleEnable ? 1 : 7, start);
      check("loadSpan", 1, (cyc - start >= e - 2) && (cyc - start <= e + 8));
   endtask

   task automatic run_dump(input logic lowPermit);
      int xf, dumpLen;
      holdValid = lowPermit;
      words = 0;
      vseen = 0;
      xf = 0;
      dumpLen = (curMode.dumpSel == 2'h0) ? 64 : (curMode.dumpSel == 2'h3) ? 256 : 128;
      while (xformBusy !== 1'b1 && xf < 50)
      begin
         tick();
         xf++;
      end
      xf = 0;
      while (xformBusy === 1'b1 && xf < 2000)
      begin
         tick();
         xf++;
      end
      check("xformSpan", 1, xf >= 1024 && xf <= 1038);
      if (lowPermit)
      begin
         repeat (8) begin step(1'b1); step(1'b0); end
         check("validHeld", 0, vseen);
         holdValid = 1'b0;
         repeat (3) step(1'b0);
         check("validOnPermit", 1, vseen);
      end
      else
      begin
         repeat (3) begin step(1'b1); step(1'b0); end
         check("validPrime3", 0, vseen);
         step(1'b1);
         step(1'b0);
         step(1'b0);
         check("validPrime4", 1, vseen);
      end
      repeat (300) begin step(1'b1); step(1'b0); end
      check("dumpWords", dumpLen, words);
      check("validEnd", 0, resultsValid);
   endtask

   // ****************************************
   // Scenarios; no 1024-point size in modes 01 and 11
   // ****************************************
   initial
   begin
      repeat (4) tick();
      rst = 1'b0;
      run_load(MULTI_SEQ, SIZE_256, OVL_NONE);
      run_dump(1'b1);
      run_load(MULTI_CONC, SIZE_256, OVL_50);
      run_dump(1'b0);
      run_load(MULTI_CONC, SIZE_2X256R, OVL_75);
      run_load(MULTI_CONC, SIZE_2X256R, OVL_DUAL_50);
      run_load(MULTI_CONC, SIZE_256, OVL_50_DIV2);
      run_load(MULTI_CONC, SIZE_8X64R, OVL_75_DIV4);
      run_load(MULTI_SEQ, SIZE_8X64R, OVL_50);
      run_load(MULTI_EXT, SIZE_256, OVL_75);
      run_load(MULTI_EXT, SIZE_4X64, OVL_50);
      stop_test();
   end
endmodule
